// *** cmb_pkg.sv ***
// Constants shared by the channel mailbox and buffer control block.
package cmb_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_BASE      = 8'h10;
   localparam int         CH_SHIFT      = 3;
   localparam logic [7:0] MBOX_BASE     = 8'h80;
   localparam logic [2:0] OFF_TAG_HI    = 3'h0;
   localparam logic [2:0] OFF_TAG_LO    = 3'h1;
   localparam logic [2:0] OFF_PTR       = 3'h2;
   localparam logic [2:0] OFF_LEN_FLAGS = 3'h3;
   localparam logic [2:0] OFF_MASK_HI   = 3'h6;
   localparam logic [2:0] OFF_MASK_LO   = 3'h7;

   // ---------------------------------------------------------------
   // Field positions of the length and flags byte
   // ---------------------------------------------------------------
   localparam int LEN_LSB   = 3;
   localparam int ERR_BIT   = 2;
   localparam int SENT_BIT  = 1;
   localparam int GOT_BIT   = 0;

   // ---------------------------------------------------------------
   // Identifier tag low byte fields
   // ---------------------------------------------------------------
   localparam int TAG_EXT_BIT = 3;

   // ---------------------------------------------------------------
   // Receive status byte fields
   // ---------------------------------------------------------------
   localparam int STAT_RAK_BIT = 7;
   localparam int STAT_RNW_BIT = 6;
   localparam int STAT_RTR_BIT = 5;

   // ---------------------------------------------------------------
   // Values
   // ---------------------------------------------------------------
   localparam logic [4:0] LINK_LEN   = 5'h00;
   localparam logic [4:0] MAX_LEN    = 5'h1F;
   localparam logic [5:0] CRC_BYTES  = 6'h02;
   localparam logic [7:0] READ_EMPTY = 8'h00;

endpackage : cmb_pkg

// *** cmb_channel_mailbox.sv ***
// Channel registers, acceptance and circular mailbox RAM of a vehicle-bus link controller.
//
// How it works
// RULE1: Length/flags byte upper five bits hold buffer length for send or receive.
// RULE2: Software programs length as data bytes plus one; thirty data bytes maximum.
// RULE3: Length k from 1 to 31 means k minus one data bytes.
// RULE4: Length zero turns the pointer field into a link to another channel.
// RULE5: Device sets error bit 2 on failed send or bad frame; software clears.
// RULE6: Software writing one to error bit aborts the pending send of that channel.
// RULE7: Sent bit 1 and got bit 0 set by device only; software clears them. Here a host write to the byte can also set them.
// RULE8: Sent or got flag set only after a clean frame or exhausted retries.
// RULE9: Each mask bit one compares that identifier bit; zero makes it don't-care.
// RULE10: Mask bits 11..4 at offset 0x06, bits 3..0 upper nibble of 0x07.
// RULE11: A 128-byte mailbox RAM answers at addresses 0x80 through 0xFF.
// RULE12: Each buffer is one status byte followed by data bytes in frame order.
// RULE13: Mailbox RAM is never cleared by reset.
// RULE14: Received ack-request, direction, remote bits go to status bits 7, 6, 5.
// RULE15: Status bits 4..0 hold received data count plus one.
// RULE16: Status byte of a send buffer is not maintained.
// RULE17: Status byte is valid after a successful reception event.
// RULE18: Incoming data ends at the reserved length or at end-of-data detection.
// RULE19: With two or more spare bytes, the check bytes are stored after data.
// RULE20: Mailbox addressing wraps from 0xFF back to 0x80.
// RULE21: First data byte sits at pointer plus one, the rest follow contiguously.
// RULE22: Seven-bit pointer is an offset from mailbox base 0x80.
// RULE23: Linked channel uses target pointer, length, got flag; own channel_accept_mask_high, error, sent.
// RULE24: Acceptance compares masked identifier and extension bit only.
// RULE25: Accepted reception overwrites the identifier tag with the received identifier.
// RULE26: Storing stops once the reserved length is filled.
// RULE27: A device-set flag wins over a software write in the same cycle.
`timescale 1ns/10ps

module cmb_channel_mailbox #(
   parameter int CHANNELS = 14
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Host register access
   input  wire logic [7:0]  host_addr,
   input  wire logic [7:0]  host_wdata,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   output logic      [7:0]  host_rdata,
   output logic             host_wait,
   // Frame reception from the bus side
   input  wire logic        rx_start,
   input  wire logic [11:0] rx_id,
   input  wire logic        rx_ext,
   input  wire logic        rx_rak,
   input  wire logic        rx_rnw,
   input  wire logic        rx_rtr,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        end_of_data_field,
   input  wire logic        rx_ok_with_ack_event,
   input  wire logic        rx_ok_without_ack_event,
   input  wire logic        rx_error_event,
   output logic             rx_hit,
   output logic      [3:0]  rx_hit_channel,
   output logic             rx_busy,
   // Frame transmission to the bus side
   input  wire logic        tx_start,
   input  wire logic [3:0]  tx_channel,
   input  wire logic        tx_byte_req,
   input  wire logic        tx_done_ok,
   input  wire logic        tx_fail,
   input  wire logic        tx_retry_exhausted,
   output logic      [4:0]  tx_data_len,
   output logic      [7:0]  tx_byte,
   output logic             tx_byte_valid,
   output logic             tx_last,
   output logic [CHANNELS-1:0] tx_enabled
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Channel registers and the mailbox hold no reset: their contents are
   // random after power-up and software must program them.
   logic [7:0]  tag_hi    [CHANNELS];
   logic [7:0]  tag_lo    [CHANNELS];
   logic [7:0]  ptr_reg   [CHANNELS];
   logic [7:0]  len_flags [CHANNELS];
   logic [7:0]  mask_hi   [CHANNELS];
   logic [3:0]  mask_lo   [CHANNELS];
   logic [7:0]  mailbox   [128];                                 // RULE11

   typedef enum {CMB_RX_IDLE, CMB_RX_DATA} cmb_rx_state_e;

   cmb_rx_state_e rx_state_q;
   logic [3:0]    rx_own_q;
   logic [3:0]    rx_eff_q;
   logic [6:0]    rx_ptr_q;
   logic [4:0]    rx_len_q;
   logic [5:0]    rx_cnt_q;
   logic [5:0]    rx_stored_q;
   logic          rx_eod_q;
   logic [2:0]    rx_cmd_q;
   logic [3:0]    tx_own_q;
   logic [6:0]    tx_ptr_q;
   logic [4:0]    tx_len_q;
   logic [4:0]    tx_idx_q;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [4:0] len_of(input logic [7:0] lf);
      len_of = lf[7:cmb_pkg::LEN_LSB];
   endfunction : len_of

   // One level of link only: a zero length redirects to the channel named
   // in the pointer low bits.
   function automatic logic [3:0] eff_chan(input logic [3:0] ch);
      logic [3:0] tgt;
      tgt = ptr_reg[ch][3:0];
      if (len_of(len_flags[ch]) == cmb_pkg::LINK_LEN && 32'(tgt) < CHANNELS) begin  // RULE4
         eff_chan = tgt;
      end else begin
         eff_chan = ch;
      end
   endfunction : eff_chan

   // Byte address inside the mailbox; the 7-bit sum wraps on its own.
   function automatic logic [6:0] mbox_idx(input logic [6:0] ptr, input logic [4:0] off);
      mbox_idx = 7'(ptr + 7'(off));                                // RULE20 RULE22
   endfunction : mbox_idx

   // ---------------------------------------------------------------
   // Host address decode
   // ---------------------------------------------------------------
   localparam int CHW = 4;

   logic           host_mbox;
   logic           host_chreg;
   logic [7:0]     host_rel;
   logic [CHW-1:0] host_ch;
   logic [2:0]     host_off;

   always_comb begin
      host_rel   = 8'(host_addr - cmb_pkg::REG_BASE);
      host_ch    = host_rel[CHW+cmb_pkg::CH_SHIFT-1:cmb_pkg::CH_SHIFT];
      host_off   = host_rel[2:0];
      host_mbox  = host_addr[7];                                   // RULE11
      host_chreg = !host_addr[7] && host_addr >= cmb_pkg::REG_BASE && 32'(host_ch) < CHANNELS;
   end

   // ---------------------------------------------------------------
   // Acceptance
   // ---------------------------------------------------------------
   logic           acc_hit;
   logic [CHW-1:0] acc_ch;

   always_comb begin
      logic [11:0] tag;
      logic [11:0] msk;
      tag     = 12'h000;
      msk     = 12'h000;
      acc_hit = 1'b0;
      acc_ch  = 4'h0;
      // Scan from the top so the lowest matching channel wins.
      for (int c = CHANNELS - 1; c >= 0; c--) begin
         tag = {tag_hi[c], tag_lo[c][7:4]};
         msk = {mask_hi[c], mask_lo[c]};                           // RULE10
         if ((((tag ^ rx_id) & msk) == 12'h000) &&                 // RULE9 RULE24
             (tag_lo[c][cmb_pkg::TAG_EXT_BIT] == rx_ext) &&       // RULE24
             !len_flags[eff_chan(4'(c))][cmb_pkg::GOT_BIT]) begin // RULE23
            acc_hit = 1'b1;
            acc_ch  = 4'(c);
         end
      end
   end

   // ---------------------------------------------------------------
   // Device event decode
   // ---------------------------------------------------------------
   logic rx_ok;
   logic rx_room;
   logic dev_we;
   logic [6:0] dev_waddr;
   logic [7:0] dev_wdata;
   logic [5:0] rx_ndata;

   always_comb begin
      rx_ok   = rx_state_q == CMB_RX_DATA && (rx_ok_with_ack_event || rx_ok_without_ack_event);
      rx_room = 6'(rx_stored_q) + 6'h01 < 6'(rx_len_q);          // RULE26
      // Check bytes stored as data are taken back off the count.
      rx_ndata = (rx_cnt_q >= cmb_pkg::CRC_BYTES) ? 6'(rx_cnt_q - cmb_pkg::CRC_BYTES) : 6'h00;  // RULE19
      dev_we    = 1'b0;
      dev_waddr = 7'h00;
      dev_wdata = 8'h00;
      if (rx_ok) begin                                             // RULE17
         dev_we    = 1'b1;
         dev_waddr = rx_ptr_q;                                     // RULE12
         dev_wdata = {rx_cmd_q,                                    // RULE14
                      (rx_ndata >= 6'(cmb_pkg::MAX_LEN)) ? cmb_pkg::MAX_LEN : 5'(rx_ndata + 6'h01)};  // RULE15
      end else if (rx_state_q == CMB_RX_DATA && rx_byte_valid && rx_room && !rx_eod_q) begin  // RULE18
         dev_we    = 1'b1;
         dev_waddr = mbox_idx(rx_ptr_q, 5'(rx_stored_q + 6'h01)); // RULE21
         dev_wdata = rx_byte;
      end
   end

   // Mailbox has one write port; the frame side cannot wait, so the host is held off.
   assign host_wait = dev_we && host_mbox && host_wr;

   // ---------------------------------------------------------------
   // Mailbox RAM
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin                                 // RULE13
      if (dev_we) begin
         mailbox[dev_waddr] <= dev_wdata;
      end else if (host_wr && host_mbox) begin
         mailbox[host_addr[6:0]] <= host_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Channel registers written by host and device
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      for (int c = 0; c < CHANNELS; c++) begin
         if (host_wr && host_chreg && 32'(host_ch) == c) begin
            case (host_off)
               cmb_pkg::OFF_TAG_HI:  tag_hi[c]  <= host_wdata;
               cmb_pkg::OFF_TAG_LO:  tag_lo[c]  <= host_wdata;
               cmb_pkg::OFF_PTR:     ptr_reg[c] <= host_wdata;
               cmb_pkg::OFF_MASK_HI: mask_hi[c] <= host_wdata;    // RULE10
               cmb_pkg::OFF_MASK_LO: mask_lo[c] <= host_wdata[7:4];
               default: ;
            endcase
         end
         if (rx_start && rx_state_q == CMB_RX_IDLE && acc_hit && 32'(acc_ch) == c) begin
            tag_hi[c]      <= rx_id[11:4];                         // RULE25
            tag_lo[c][7:4] <= rx_id[3:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int c = 0; c < CHANNELS; c++) begin
         logic [7:0] nxt;
         nxt = len_flags[c];
         if (host_wr && host_chreg && 32'(host_ch) == c && host_off == cmb_pkg::OFF_LEN_FLAGS) begin
            nxt = host_wdata;                                      // RULE1 RULE6 RULE7
         end
         // Device sets are applied after the host write so they win.
         if (rx_ok && 32'(rx_eff_q) == c) begin
            nxt[cmb_pkg::GOT_BIT] = 1'b1;                          // RULE8 RULE23 RULE27
         end
         if (rx_state_q == CMB_RX_DATA && rx_error_event && 32'(rx_own_q) == c) begin
            nxt[cmb_pkg::ERR_BIT] = 1'b1;                          // RULE5 RULE27
         end
         if ((tx_done_ok || tx_retry_exhausted) && 32'(tx_own_q) == c) begin
            nxt[cmb_pkg::SENT_BIT] = 1'b1;                         // RULE8 RULE23
         end
         if ((tx_fail || tx_retry_exhausted) && 32'(tx_own_q) == c) begin
            nxt[cmb_pkg::ERR_BIT] = 1'b1;                          // RULE5
         end
         len_flags[c] <= nxt;
      end
   end

   // ---------------------------------------------------------------
   // Reception sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_state_q  <= CMB_RX_IDLE;
         rx_own_q    <= 4'h0;
         rx_eff_q    <= 4'h0;
         rx_ptr_q    <= 7'h00;
         rx_len_q    <= 5'h00;
         rx_cnt_q    <= 6'h00;
         rx_stored_q <= 6'h00;
         rx_eod_q    <= 1'b0;
         rx_cmd_q    <= 3'h0;
      end else begin
         case (rx_state_q)
            CMB_RX_IDLE: begin
               if (rx_start && acc_hit) begin
                  rx_state_q  <= CMB_RX_DATA;
                  rx_own_q    <= acc_ch;
                  rx_eff_q    <= eff_chan(acc_ch);                 // RULE23
                  rx_ptr_q    <= ptr_reg[eff_chan(acc_ch)][6:0];   // RULE22
                  rx_len_q    <= len_of(len_flags[eff_chan(acc_ch)]);
                  rx_cnt_q    <= 6'h00;
                  rx_stored_q <= 6'h00;
                  rx_eod_q    <= 1'b0;
                  rx_cmd_q    <= {rx_rak, rx_rnw, rx_rtr};         // RULE14
               end
            end
            CMB_RX_DATA: begin
               if (rx_ok || rx_error_event) begin
                  rx_state_q <= CMB_RX_IDLE;
               end else begin
                  if (end_of_data_field) begin
                     rx_eod_q <= 1'b1;                             // RULE18
                  end
                  if (rx_byte_valid && !rx_eod_q) begin
                     if (rx_cnt_q != 6'h3F) begin
                        rx_cnt_q <= 6'(rx_cnt_q + 6'h01);
                     end
                     if (rx_room) begin
                        rx_stored_q <= 6'(rx_stored_q + 6'h01);    // RULE26
                     end
                  end
               end
            end
            default: rx_state_q <= CMB_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_hit         <= 1'b0;
         rx_hit_channel <= 4'h0;
      end else begin
         rx_hit <= rx_start && rx_state_q == CMB_RX_IDLE && acc_hit;
         if (rx_start && rx_state_q == CMB_RX_IDLE && acc_hit) begin
            rx_hit_channel <= acc_ch;
         end
      end
   end

   assign rx_busy = rx_state_q == CMB_RX_DATA;

   // ---------------------------------------------------------------
   // Transmission data path
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_own_q      <= 4'h0;
         tx_ptr_q      <= 7'h00;
         tx_len_q      <= 5'h00;
         tx_idx_q      <= 5'h00;
         tx_data_len   <= 5'h00;
         tx_byte       <= 8'h00;
         tx_byte_valid <= 1'b0;
         tx_last       <= 1'b0;
      end else begin
         tx_byte_valid <= 1'b0;
         if (tx_start) begin
            tx_own_q    <= tx_channel;
            tx_ptr_q    <= ptr_reg[eff_chan(tx_channel)][6:0];     // RULE22 RULE23
            tx_len_q    <= len_of(len_flags[eff_chan(tx_channel)]);
            tx_data_len <= (len_of(len_flags[eff_chan(tx_channel)]) == 5'h00) ? 5'h00 :
                           5'(len_of(len_flags[eff_chan(tx_channel)]) - 5'h01);  // RULE3
            tx_idx_q    <= 5'h00;
         end else if (tx_byte_req && 6'(tx_idx_q) + 6'h01 < 6'(tx_len_q)) begin
            // The status byte at the pointer is skipped; it means nothing here.
            tx_byte       <= mailbox[mbox_idx(tx_ptr_q, 5'(tx_idx_q + 5'h01))];  // RULE16 RULE21
            tx_byte_valid <= 1'b1;
            tx_last       <= 6'(tx_idx_q) + 6'h02 == 6'(tx_len_q);
            tx_idx_q      <= 5'(tx_idx_q + 5'h01);
         end
      end
   end

   // A channel stays armed while unsent and not aborted by the error bit.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_enabled <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            tx_enabled[c] <= !len_flags[c][cmb_pkg::SENT_BIT] && !len_flags[c][cmb_pkg::ERR_BIT];  // RULE6
         end
      end
   end

   // ---------------------------------------------------------------
   // Host read
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata <= 8'h00;
      end else if (host_rd) begin
         if (host_mbox) begin
            host_rdata <= mailbox[host_addr[6:0]];
         end else if (host_chreg) begin
            case (host_off)
               cmb_pkg::OFF_TAG_HI:    host_rdata <= tag_hi[host_ch];
               cmb_pkg::OFF_TAG_LO:    host_rdata <= tag_lo[host_ch];
               cmb_pkg::OFF_PTR:       host_rdata <= ptr_reg[host_ch];
               cmb_pkg::OFF_LEN_FLAGS: host_rdata <= len_flags[host_ch];
               cmb_pkg::OFF_MASK_HI:   host_rdata <= mask_hi[host_ch];
               cmb_pkg::OFF_MASK_LO:   host_rdata <= {mask_lo[host_ch], 4'h0};
               default:                host_rdata <= cmb_pkg::READ_EMPTY;
            endcase
         end else begin
            host_rdata <= cmb_pkg::READ_EMPTY;
         end
      end
   end

endmodule : cmb_channel_mailbox

// *** cmb_monitor.sv ***
// Port assertions for the channel mailbox block.
`timescale 1ns/10ps
module cmb_monitor #(parameter int CHANNELS = 14) (
   // Watched ports
   input wire logic       mclk, rst_b, host_wr, host_rd, host_wait, rx_start, rx_busy, rx_hit,
   input wire logic       rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event,
   input wire logic       tx_byte_req, tx_byte_valid,
   input wire logic [7:0] host_addr, host_rdata,
   input wire logic [3:0] rx_hit_channel,
   input wire logic [4:0] tx_data_len
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire end_ev = rx_ok_with_ack_event | rx_ok_without_ack_event | rx_error_event;
   chk_hit_cause: assert property (rx_hit |-> $past(rx_start) && !$past(rx_busy))
      else $error("rx_hit without an idle rx_start");
   chk_hit_busy: assert property (rx_hit |-> rx_busy ##1 !rx_hit)
      else $error("rx_hit not a pulse with busy");
   chk_hit_range: assert property (rx_hit |-> rx_hit_channel < CHANNELS)
      else $error("rx_hit_channel out of range");
   chk_busy_end: assert property (rx_busy && end_ev |=> !rx_busy)
      else $error("rx_busy held after closing event");
   chk_start_busy: assert property (rx_busy && rx_start |=> !rx_hit)
      else $error("rx_start accepted while busy");
   chk_valid_cause: assert property (tx_byte_valid |-> $past(tx_byte_req))
      else $error("tx_byte_valid without request");
   chk_len_range: assert property (tx_data_len != 5'h1F)
      else $error("tx_data_len above thirty");
   chk_wait_mbox: assert property (host_wait |-> host_wr && host_addr[7])
      else $error("host_wait outside mailbox write");
   chk_mask_nibble: assert property (host_rd && !host_addr[7] && host_addr[6:4] != 3'h0
      && host_addr[2:0] == 3'h7 |=> host_rdata[3:0] == 4'h0)
      else $error("mask low nibble not zero");
   cov_hit: cover property (rx_hit);
   cov_tx: cover property (tx_byte_valid);
   cov_end: cover property (rx_busy && end_ev);
endmodule : cmb_monitor
bind cmb_channel_mailbox cmb_monitor #(.CHANNELS(CHANNELS)) u_mon (.mclk(mclk), .rst_b(rst_b),
   .host_wr(host_wr), .host_rd(host_rd), .host_wait(host_wait), .rx_start(rx_start), .rx_busy(rx_busy),
   .rx_hit(rx_hit), .rx_ok_with_ack_event(rx_ok_with_ack_event), .rx_error_event(rx_error_event),
   .rx_ok_without_ack_event(rx_ok_without_ack_event), .tx_byte_req(tx_byte_req),
   .tx_byte_valid(tx_byte_valid), .host_addr(host_addr), .host_rdata(host_rdata),
   .rx_hit_channel(rx_hit_channel), .tx_data_len(tx_data_len));

// *** cmb_bus_node.sv ***
// Bus-side node model that delivers frames to the block.
`timescale 1ns/10ps
module cmb_bus_node (
   // Clock
   input  wire logic        mclk,
   // Frame signals toward the block
   output logic             rx_start, rx_ext, rx_rak, rx_rnw, rx_rtr, rx_byte_valid, end_of_data_field,
   output logic             rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event,
   output logic [11:0]      rx_id,
   output logic [7:0]       rx_byte
);
   initial begin
      {rx_start, rx_ext, rx_rak, rx_rnw, rx_rtr, rx_byte_valid, end_of_data_field} = '0;
      {rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event} = '0;
      rx_id = 12'h000;
      rx_byte = 8'h00;
   end
   // Data, then two check bytes, then the end mark with a stray start, then one closing event.
   task automatic send(input logic [11:0] id, input logic [3:0] cmd, input int nd, input logic [7:0] b0,
                       input int ev);
      @(negedge mclk);
      rx_start = 1'b1;
      rx_id = id;
      {rx_ext, rx_rak, rx_rnw, rx_rtr} = cmd;
      @(negedge mclk);
      rx_start = 1'b0;
      rx_id = ~id;
      for (int i = 0; i < nd + 2; i++) begin
         @(negedge mclk);
         rx_byte_valid = 1'b1;
         rx_byte = (i < nd) ? b0 + 8'(i) : 8'hC0 + 8'(i - nd);
         @(negedge mclk);
         rx_byte_valid = 1'b0;
         rx_byte = ~rx_byte;
      end
      @(negedge mclk);
      end_of_data_field = 1'b1;
      rx_start = 1'b1;
      rx_id = id;
      @(negedge mclk);
      end_of_data_field = 1'b0;
      rx_start = 1'b0;
      {rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event} = 3'h4 >> ev;
      @(negedge mclk);
      {rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event} = '0;
   endtask : send
endmodule : cmb_bus_node

// *** test_cmb_channel_mailbox.sv ***
// Self-checking testbench for the channel mailbox block.
`timescale 1ns/10ps
module test_cmb_channel_mailbox;
   logic mclk = 1'b0, rst_b = 1'b0, host_wr = 1'b0, host_rd = 1'b0, tx_start = 1'b0, tx_byte_req = 1'b0;
   logic tx_done_ok = 1'b0, tx_fail = 1'b0, tx_retry_exhausted = 1'b0;
   logic host_wait, rx_hit, rx_busy, tx_byte_valid, tx_last, rx_start, rx_ext, rx_rak, rx_rnw, rx_rtr;
   logic rx_byte_valid, end_of_data_field, rx_ok_with_ack_event, rx_ok_without_ack_event, rx_error_event;
   logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, tx_byte, rd_v, rx_byte;
   logic [3:0] tx_channel = 4'h0, rx_hit_channel, hit_ch;
   logic [4:0] tx_data_len;
   logic [13:0] tx_enabled;
   logic [11:0] rx_id;
   int miscompares = 0, checks = 0, hits = 0;
   cmb_channel_mailbox u_dut (.mclk, .rst_b, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
      .host_wait, .rx_start, .rx_id, .rx_ext, .rx_rak, .rx_rnw, .rx_rtr, .rx_byte_valid, .rx_byte,
      .end_of_data_field, .rx_ok_with_ack_event, .rx_ok_without_ack_event, .rx_error_event, .rx_hit,
      .rx_hit_channel, .rx_busy, .tx_start, .tx_channel, .tx_byte_req, .tx_done_ok, .tx_fail,
      .tx_retry_exhausted, .tx_data_len, .tx_byte, .tx_byte_valid, .tx_last, .tx_enabled);
   cmb_bus_node u_node (.mclk, .rx_start, .rx_ext, .rx_rak, .rx_rnw, .rx_rtr, .rx_byte_valid,
      .end_of_data_field, .rx_ok_with_ack_event, .rx_ok_without_ack_event, .rx_error_event, .rx_id, .rx_byte);
   always #2.5 mclk = ~mclk;
   always @(negedge mclk) if (rx_hit === 1'b1) begin
      hits++;
      hit_ch = rx_hit_channel;
   end
   function automatic logic [7:0] ra(input int c, input logic [2:0] o);
      return cmb_pkg::REG_BASE + 8'(c << cmb_pkg::CH_SHIFT) + 8'(o);
   endfunction : ra
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge mclk);
      host_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge mclk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge mclk);
      host_rd = 1'b0;
      rd_v = host_rdata;
   endtask : rd
   task automatic t_regs;
      for (int c = 0; c < 14; c++) wr(ra(c, 3'h3), 8'h0B);
      wr(ra(0, 3'h6), 8'hA5);
      wr(ra(0, 3'h7), 8'h3F);
      rd(ra(0, 3'h6)); chk("mask_hi", rd_v, 8'hA5);
      rd(ra(0, 3'h7)); chk("mask_lo", rd_v, 8'h30);
      rd(ra(0, 3'h4)); chk("hole", rd_v, 8'h00);
      chk("tx_en_off", tx_enabled, 14'h0000);
   endtask : t_regs
   task automatic t_rx;
      wr(ra(0, 3'h0), 8'h10);
      wr(ra(0, 3'h1), 8'h00);
      wr(ra(0, 3'h2), 8'h7E);
      wr(ra(0, 3'h6), 8'hF0);
      wr(ra(0, 3'h7), 8'h00);
      wr(8'h82, 8'h77);
      wr(ra(0, 3'h3), 8'h20);
      u_node.send(12'h12A, 4'h5, 3, 8'hD0, 0);
      chk("hits", hits, 1); chk("hit_ch", hit_ch, 4'h0);
      rd(8'hFE); chk("status", rd_v, 8'hA4);
      rd(8'hFF); chk("data0", rd_v, 8'hD0);
      rd(8'h80); chk("data1", rd_v, 8'hD1);
      rd(8'h81); chk("data2", rd_v, 8'hD2);
      rd(8'h82); chk("beyond", rd_v, 8'h77);
      rd(ra(0, 3'h3)); chk("got", rd_v, 8'h21);
      rd(ra(0, 3'h0)); chk("tag", rd_v, 8'h12);
      u_node.send(12'h12A, 4'h5, 1, 8'hD0, 0);
      chk("refused", hits, 1);
      wr(ra(0, 3'h2), 8'h00);
      wr(ra(0, 3'h3), 8'h30);
      u_node.send(12'h1FF, 4'h0, 2, 8'hE0, 1);
      rd(8'h80); chk("status2", rd_v, 8'h03);
      rd(8'h83); chk("crc0", rd_v, 8'hC0);
      rd(8'h84); chk("crc1", rd_v, 8'hC1);
      wr(ra(0, 3'h3), 8'h30);
      u_node.send(12'h100, 4'h0, 1, 8'hE0, 2);
      rd(ra(0, 3'h3)); chk("err", rd_v, 8'h34);
      u_node.send(12'h100, 4'h8, 1, 8'hE0, 0); chk("ext", hits, 3);
   endtask : t_rx
   task automatic t_tx;
      wr(ra(1, 3'h2), 8'h10);
      wr(8'h91, 8'h3C);
      wr(8'h92, 8'h4D);
      wr(ra(1, 3'h3), 8'h18);
      wr(ra(2, 3'h3), 8'h10);
      @(negedge mclk);
      chk("tx_en", tx_enabled, 14'h0006);
      wr(ra(2, 3'h3), 8'h14);
      @(negedge mclk);
      chk("abort", tx_enabled, 14'h0002);
      tx_start = 1'b1;
      tx_channel = 4'h1;
      @(negedge mclk);
      tx_start = 1'b0;
      chk("tx_len", tx_data_len, 5'h02);
      for (int i = 0; i < 3; i++) begin
         @(negedge mclk) tx_byte_req = 1'b1;
         @(negedge mclk) tx_byte_req = 1'b0;
         chk("tx_valid", tx_byte_valid, i < 2);
         if (i < 2) chk("tx_byte", tx_byte, i ? 8'h4D : 8'h3C);
         if (i < 2) chk("tx_last", tx_last, i);
      end
      @(negedge mclk) tx_done_ok = 1'b1;
      @(negedge mclk) tx_done_ok = 1'b0;
      @(negedge mclk);
      chk("sent_off", tx_enabled[1], 1'b0);
      rd(ra(1, 3'h3)); chk("sent", rd_v, 8'h1A);
      wr(ra(1, 3'h3), 8'h18);
      @(negedge mclk) tx_fail = 1'b1;
      @(negedge mclk) tx_fail = 1'b0;
      rd(ra(1, 3'h3)); chk("fail", rd_v, 8'h1C);
   endtask : t_tx
   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      #50000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst_b = 1'b1;
      t_regs();
      t_rx();
      t_tx();
      conclude();
   end
endmodule : test_cmb_channel_mailbox
